// File: hw/tick_timers_soft_interrupts.v
// timer counters, match comparators and soft interrupt pending register,
// reached by state-register read and write instructions of the pipeline
// assumes one access per cycle, rst is the power-on reset, sys_clk_in slow
`timescale 1ns/1ps
`include "tick_timers_regs.vh"
module tick_timers_soft_interrupts (
  input wire clk,
  input wire rst,
  input wire acc_valid,
  input wire acc_write,
  input wire [4:0] acc_reg,
  input wire [63:0] acc_wdata,
  input wire priv_mode,
  input wire global_irq_enable,
  input wire [3:0] priority_threshold,
  input wire perf_counter_overflow,
  input wire sys_clk_in,
  output reg acc_done,
  output reg [63:0] acc_rdata,
  output reg priv_action_trap,
  output reg priv_opcode_trap,
  output reg illegal_trap,
  output reg [15:1] irq_levels,
  output reg irq_take,
  output reg [3:0] irq_level_taken,
  output reg [16:0] soft_interrupt_pending
);

  ////////////////////////////////////////////////////////////////////////
  // decode

  // true when the register number names a privileged-only register
  function is_priv_only;
    input [4:0] r;
    begin
      is_priv_only = (r == `ASR_PENDING_SET) || (r == `ASR_PENDING_CLEAR) ||
        (r == `ASR_SOFT_PENDING) || (r == `ASR_CYCLE_MATCH) ||
        (r == `ASR_SYSTEM_MATCH);
    end
  endfunction

  // true when the register number is one of the two counters
  function is_counter;
    input [4:0] r;
    begin
      is_counter = (r == `ASR_CYCLE_COUNTER) || (r == `ASR_SYSTEM_COUNTER);
    end
  endfunction

  wire hit_priv = is_priv_only(acc_reg);
  wire hit_cnt = is_counter(acc_reg);
  wire wo_reg = (acc_reg == `ASR_PENDING_SET) || (acc_reg == `ASR_PENDING_CLEAR);
  wire [63:0] cyc_value;
  wire [63:0] cyc_cmp;
  wire [63:0] sys_value;
  wire [63:0] sys_cmp;
  wire cyc_hit;
  wire sys_hit;
  wire sys_inc;

  // trap classes: opcode trap for privileged-only or user counter write, action trap for blocked read
  wire opc_fault = acc_valid & ~priv_mode &
    (hit_priv | (hit_cnt & acc_write));
  wire blk_bit = (acc_reg == `ASR_CYCLE_COUNTER) ? cyc_value[`TOP_BIT] :
    sys_value[`TOP_BIT];
  wire act_fault = acc_valid & ~priv_mode & hit_cnt & ~acc_write &
    blk_bit;
  // reading a write-only register or touching an unmapped number
  wire ill_fault = acc_valid & ~opc_fault & ~act_fault &
    ((~hit_priv & ~hit_cnt) | (wo_reg & ~acc_write));
  wire ok = acc_valid & ~opc_fault & ~act_fault & ~ill_fault;
  wire wr_ok = ok & acc_write;

  ////////////////////////////////////////////////////////////////////////
  // counters

  // system clock edges cross into clk before touching count or compare
  sys_tick_sync u_sync (
    .clk(clk),
    .rst(rst),
    .sys_clk_in(sys_clk_in),
    .tick_pulse(sys_inc)
  );

  // processor cycle counter, steps every clock
  match_counter u_cycle (
    .clk(clk),
    .por(rst),
    .inc(1'b1),
    .cnt_we(wr_ok & (acc_reg == `ASR_CYCLE_COUNTER)),
    .cmp_we(wr_ok & (acc_reg == `ASR_CYCLE_MATCH)),
    .wdata(acc_wdata),
    .cnt_value(cyc_value),
    .cmp_value(cyc_cmp),
    .match_hit(cyc_hit)
  );

  // system counter, steps once per synchronised system clock edge
  match_counter u_system (
    .clk(clk),
    .por(rst),
    .inc(sys_inc),
    .cnt_we(wr_ok & (acc_reg == `ASR_SYSTEM_COUNTER)),
    .cmp_we(wr_ok & (acc_reg == `ASR_SYSTEM_MATCH)),
    .wdata(acc_wdata),
    .cnt_value(sys_value),
    .cmp_value(sys_cmp),
    .match_hit(sys_hit)
  );

  ////////////////////////////////////////////////////////////////////////
  // pending register

  reg [16:0] nxt_pending;

  // write, set and clear first; hardware matches win over any clear
  always @* begin
    nxt_pending = soft_interrupt_pending;
    if (wr_ok && acc_reg == `ASR_SOFT_PENDING) begin
      nxt_pending = acc_wdata[16:0];
    end
    if (wr_ok && acc_reg == `ASR_PENDING_SET) begin
      nxt_pending = nxt_pending | acc_wdata[16:0];
    end
    if (wr_ok && acc_reg == `ASR_PENDING_CLEAR) begin
      nxt_pending = nxt_pending & ~acc_wdata[16:0];
    end
    if (cyc_hit) begin
      nxt_pending[`PEND_CYCLE_BIT] = 1'b1;
    end
    if (sys_hit) begin
      nxt_pending[`PEND_SYSTEM_BIT] = 1'b1;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      soft_interrupt_pending <= `PEND_RESET;
    end else begin
      soft_interrupt_pending <= nxt_pending;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupt levels

  reg [15:1] nxt_levels;
  reg [3:0] nxt_top;
  integer i;

  // level 14 gathers both matches, level 15 gathers overflow
  always @* begin
    nxt_levels = soft_interrupt_pending[`PEND_LEVEL_MSB:`PEND_LEVEL_LSB];
    nxt_levels[14] = nxt_levels[14] | soft_interrupt_pending[`PEND_CYCLE_BIT] |
      soft_interrupt_pending[`PEND_SYSTEM_BIT];
    nxt_levels[15] = nxt_levels[15] | perf_counter_overflow;
    nxt_top = 4'h0;
    for (i = 1; i <= 15; i = i + 1) begin
      if (nxt_levels[i]) begin
        nxt_top = i[3:0];
      end
    end
  end

  // a request is taken only above the threshold with interrupts on
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_levels <= 15'h0000;
      irq_take <= 1'b0;
      irq_level_taken <= 4'h0;
    end else begin
      irq_levels <= nxt_levels;
      irq_take <= global_irq_enable & (nxt_top > priority_threshold);
      irq_level_taken <= nxt_top;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // access answer

  reg [63:0] nxt_rdata;

  // read mux; blocked or faulting reads return zero
  always @* begin
    nxt_rdata = 64'h0000_0000_0000_0000;
    if (ok && !acc_write) begin
      case (acc_reg)
        `ASR_CYCLE_COUNTER: nxt_rdata = cyc_value;
        `ASR_SYSTEM_COUNTER: nxt_rdata = sys_value;
        `ASR_CYCLE_MATCH: nxt_rdata = cyc_cmp;
        `ASR_SYSTEM_MATCH: nxt_rdata = sys_cmp;
        `ASR_SOFT_PENDING: nxt_rdata = {47'h0, soft_interrupt_pending};
        default: nxt_rdata = 64'h0000_0000_0000_0000;
      endcase
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      acc_done <= 1'b0;
      acc_rdata <= 64'h0000_0000_0000_0000;
      priv_action_trap <= 1'b0;
      priv_opcode_trap <= 1'b0;
      illegal_trap <= 1'b0;
    end else begin
      acc_done <= acc_valid;
      acc_rdata <= nxt_rdata;
      priv_action_trap <= act_fault;
      priv_opcode_trap <= opc_fault;
      illegal_trap <= ill_fault;
    end
  end
endmodule // tick_timers_soft_interrupts

// File: hw/tick_timers_regs.vh
// register numbers, field positions and reset values for the tick timers
// assumes inclusion by the timer block files only
`ifndef TICK_TIMERS_REGS_VH
`define TICK_TIMERS_REGS_VH

`define ASR_CYCLE_COUNTER 5'h04
`define ASR_PENDING_SET 5'h14
`define ASR_PENDING_CLEAR 5'h15
`define ASR_SOFT_PENDING 5'h16
`define ASR_CYCLE_MATCH 5'h17
`define ASR_SYSTEM_COUNTER 5'h18
`define ASR_SYSTEM_MATCH 5'h19

`define TOP_BIT 63
`define COUNT_MSB 62
`define PEND_WIDTH 17
`define PEND_CYCLE_BIT 0
`define PEND_SYSTEM_BIT 16
`define PEND_LEVEL_LSB 1
`define PEND_LEVEL_MSB 15
`define LEVEL_MATCH_VAL 4'hE

`define COUNT_RESET 63'h0
`define COUNT_ONE 63'h1
`define PEND_RESET 17'h0_0000
`define BLOCK_RESET 1'b1

`endif

// File: hw/sys_tick_sync.v
// synchronises the system clock level into the processor clock and
// emits one pulse per rising edge of the system clock
// assumes sys_clk_in is far slower than clk (under half its rate)
`timescale 1ns/1ps
module sys_tick_sync (
  input wire clk,
  input wire rst,
  input wire sys_clk_in,
  output reg tick_pulse
);
  reg meta_ff;
  reg sync_ff;
  reg last_ff;

  // two-flop synchroniser then edge detect on the second stage only
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      last_ff <= 1'b0;
      tick_pulse <= 1'b0;
    end else begin
      meta_ff <= sys_clk_in;
      sync_ff <= meta_ff;
      last_ff <= sync_ff;
      tick_pulse <= sync_ff & ~last_ff;
    end
  end
endmodule // sys_tick_sync

// File: hw/match_counter.v
// one 63-bit up-counter with a user-read block bit, a match register and
// its disable bit; the count steps whenever inc is high and cnt_we is low
// assumes the parent has already decided privilege for every write strobe
`timescale 1ns/1ps
`include "tick_timers_regs.vh"
module match_counter (
  input wire clk,
  input wire por,
  input wire inc,
  input wire cnt_we,
  input wire cmp_we,
  input wire [63:0] wdata,
  output wire [63:0] cnt_value,
  output wire [63:0] cmp_value,
  output reg match_hit
);
  reg block_ff;
  reg [62:0] count_ff;
  reg dis_ff;
  reg [62:0] cmp_ff;

  assign cnt_value = {block_ff, count_ff};
  assign cmp_value = {dis_ff, cmp_ff};

  // only power-on reset loads state (count zero, block bit set); other resets never reach here
  always @(posedge clk or posedge por) begin
    if (por) begin
      block_ff <= `BLOCK_RESET;
      count_ff <= `COUNT_RESET;
    end else if (cnt_we) begin
      block_ff <= wdata[`TOP_BIT];
      count_ff <= wdata[`COUNT_MSB:0];
    end else if (inc) begin
      count_ff <= count_ff + `COUNT_ONE;
    end
  end

  // match register: disabled with zero value after power-on
  always @(posedge clk or posedge por) begin
    if (por) begin
      dis_ff <= `BLOCK_RESET;
      cmp_ff <= `COUNT_RESET;
    end else if (cmp_we) begin
      dis_ff <= wdata[`TOP_BIT];
      cmp_ff <= wdata[`COUNT_MSB:0];
    end
  end

  // exact equality, one pulse per count value reached
  always @(posedge clk or posedge por) begin
    if (por) begin
      match_hit <= 1'b0;
    end else begin
      match_hit <= ~dis_ff & (cmp_ff == count_ff) & inc;
    end
  end
endmodule // match_counter

// File: verif/tick_timers_asserts.sv
// port checker for the timer and soft interrupt block
// assumes binding onto tick_timers_soft_interrupts, rst is power-on
`timescale 1ns/1ps
module tick_timers_asserts (
  input wire clk,
  input wire rst,
  input wire acc_valid,
  input wire acc_write,
  input wire [4:0] acc_reg,
  input wire [63:0] acc_wdata,
  input wire priv_mode,
  input wire acc_done,
  input wire [63:0] acc_rdata,
  input wire priv_opcode_trap,
  input wire illegal_trap,
  input wire [15:1] irq_levels,
  input wire [16:0] soft_interrupt_pending
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////
  // access classes; bits 0 and 16 left out since hardware match may set them
  wire usr = acc_valid & ~priv_mode;
  wire wr_p = acc_valid & acc_write & priv_mode;
  a_done_one_cycle: assert property (acc_valid |=> acc_done) else $error("no answer");
  a_user_counter_write: assert property (
    usr && acc_write && (acc_reg == 5'h04 || acc_reg == 5'h18) |=> priv_opcode_trap)
    else $error("user counter write not trapped");
  a_user_match_trap: assert property (
    usr && (acc_reg == 5'h17 || acc_reg == 5'h19) |=> priv_opcode_trap)
    else $error("user match access not trapped");
  a_user_pend_trap: assert property (
    usr && acc_reg >= 5'h14 && acc_reg <= 5'h16 |=> priv_opcode_trap)
    else $error("user pending access not trapped");
  a_set_ones: assert property (wr_p && acc_reg == 5'h14 |=>
    soft_interrupt_pending[15:1] == ($past(soft_interrupt_pending[15:1]) | $past(acc_wdata[15:1])))
    else $error("set register wrong");
  a_clear_ones: assert property (wr_p && acc_reg == 5'h15 |=>
    soft_interrupt_pending[15:1] == ($past(soft_interrupt_pending[15:1]) & ~$past(acc_wdata[15:1])))
    else $error("clear register wrong");
  a_level_follow: assert property (
    irq_levels[13:1] == $past(soft_interrupt_pending[13:1])) else $error("levels lag wrong");
  a_cycle_level: assert property (soft_interrupt_pending[0] |=> irq_levels[14])
    else $error("cycle match level missing");
  a_system_level: assert property (soft_interrupt_pending[16] |=> irq_levels[14])
    else $error("system match level missing");
  a_read_set_illegal: assert property (
    acc_valid && !acc_write && priv_mode && (acc_reg == 5'h14 || acc_reg == 5'h15)
    |=> illegal_trap && acc_rdata == 64'h0) else $error("write-only read not refused");
endmodule // tick_timers_asserts
bind tick_timers_soft_interrupts tick_timers_asserts u_tick_timers_asserts (.*);

// File: verif/sys_clock_source.sv
// model of the system clock feeding the timer block
// free running, phase unrelated to the processor clock
`timescale 1ns/1ps
module sys_clock_source (
  output reg sys_clk_out
);
  // 74 ns period keeps it well under half the processor rate
  initial sys_clk_out = 1'b0;
  always #37 sys_clk_out = ~sys_clk_out;
endmodule // sys_clock_source

// File: verif/tick_timers_soft_interrupts_tb.sv
// bench for the timer and soft interrupt block
// assumes the system clock model and the port checker alongside
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin fail_count++; $display("Error %s exp %h got %h", n, e, g); end end
module tick_timers_soft_interrupts_tb;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg acc_valid = 1'b0;
  reg acc_write = 1'b0;
  reg [4:0] acc_reg = 5'h00;
  reg [63:0] acc_wdata = 64'h0;
  reg priv_mode = 1'b1;
  reg global_irq_enable = 1'b1;
  reg [3:0] priority_threshold = 4'hd;
  reg perf_counter_overflow = 1'b0;
  wire sys_clk_in;
  wire acc_done, priv_action_trap, priv_opcode_trap, illegal_trap, irq_take;
  wire [63:0] acc_rdata;
  wire [15:1] irq_levels;
  wire [3:0] irq_level_taken;
  wire [16:0] soft_interrupt_pending;
  integer fail_count = 0;
  integer checks = 0;
  reg [63:0] rd;
  reg [63:0] r0;
  reg [2:0] trp;
  always #2.5 clk = ~clk;
  sys_clock_source u_sys_clock_source (.sys_clk_out(sys_clk_in));
  tick_timers_soft_interrupts u_tick_timers_soft_interrupts (.clk(clk), .rst(rst),
    .acc_valid(acc_valid), .acc_write(acc_write), .acc_reg(acc_reg), .acc_wdata(acc_wdata),
    .priv_mode(priv_mode), .global_irq_enable(global_irq_enable),
    .priority_threshold(priority_threshold), .perf_counter_overflow(perf_counter_overflow),
    .sys_clk_in(sys_clk_in), .acc_done(acc_done), .acc_rdata(acc_rdata),
    .priv_action_trap(priv_action_trap), .priv_opcode_trap(priv_opcode_trap),
    .illegal_trap(illegal_trap), .irq_levels(irq_levels), .irq_take(irq_take),
    .irq_level_taken(irq_level_taken), .soft_interrupt_pending(soft_interrupt_pending));
  ////////////////////
  // one access; the answer is fixed at one cycle, so no wait loop
  task acc(input w, input [4:0] r, input [63:0] d, input p);
    begin
      @(posedge clk);
      acc_valid <= 1'b1;
      acc_write <= w;
      acc_reg <= r;
      acc_wdata <= d;
      priv_mode <= p;
      @(posedge clk);
      acc_valid <= 1'b0;
      #1;
      `CHK("done", 1'b1, acc_done)
      rd = acc_rdata;
      trp = {priv_action_trap, priv_opcode_trap, illegal_trap};
    end
  endtask
  // bounded wait for a match flag
  task wait_bit(input integer b, input integer lim);
    integer i;
    begin
      i = 0;
      while (soft_interrupt_pending[b] !== 1'b1 && i < lim) begin
        @(posedge clk);
        #1;
        i = i + 1;
      end
      `CHK("match pending", 1'b1, soft_interrupt_pending[b])
      if (i == lim) finish_test;
    end
  endtask
  task finish_test;
    begin
      if (fail_count == 0 && checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
    end
  endtask
  ////////////////////
  // main sequence
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    acc(0, 5'h04, 64'h0, 0);
    `CHK("cycle block", 3'b100, trp)
    acc(0, 5'h18, 64'h0, 0);
    `CHK("system block", 3'b100, trp)
    acc(0, 5'h19, 64'h0, 1);
    `CHK("system match reset", 64'h8000_0000_0000_0000, rd)
    acc(1, 5'h14, 64'hfffe_0000_0000_00f0, 1);
    acc(1, 5'h15, 64'h30, 1);
    acc(0, 5'h16, 64'h0, 1);
    `CHK("pending", 64'hc0, rd)
    `CHK("levels", 15'h0060, irq_levels)
    `CHK("low level not taken", 1'b0, irq_take)
    acc(0, 5'h14, 64'h0, 1);
    `CHK("read set", 3'b001, trp)
    acc(0, 5'h1f, 64'h0, 1);
    `CHK("unmapped", 3'b001, trp)
    acc(0, 5'h16, 64'h0, 0);
    `CHK("user pending", 3'b010, trp)
    acc(0, 5'h17, 64'h0, 0);
    `CHK("user match", 3'b010, trp)
    // counter write, refused user write, then a free user read and a privileged read
    acc(1, 5'h04, 64'h64, 1);
    acc(1, 5'h04, 64'h0, 0);
    `CHK("user write trap", 3'b010, trp)
    acc(0, 5'h04, 64'h0, 0);
    `CHK("user read ok", 3'b000, trp)
    `CHK("count from write", 1'b1, rd > 64'h64 && rd < 64'h6e)
    r0 = rd;
    acc(0, 5'h04, 64'h0, 1);
    `CHK("cycle rate", 64'h2, rd - r0)
    // disabled match posts nothing, enabled one does
    acc(1, 5'h17, 64'h8000_0000_0000_0096, 1);
    repeat (60) @(posedge clk);
    #1;
    `CHK("disabled match", 1'b0, soft_interrupt_pending[0])
    acc(1, 5'h17, 64'hc8, 1);
    wait_bit(0, 200);
    repeat (2) @(posedge clk);
    #1;
    `CHK("level 14", 1'b1, irq_levels[14])
    `CHK("take 14", 5'h1e, {irq_take, irq_level_taken})
    @(posedge clk);
    priority_threshold <= 4'he;
    repeat (3) @(posedge clk);
    #1;
    `CHK("masked 14", 1'b0, irq_take)
    @(posedge clk);
    perf_counter_overflow <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    `CHK("take 15", 5'h1f, {irq_take, irq_level_taken})
    @(posedge clk);
    global_irq_enable <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    `CHK("enable off", 1'b0, irq_take)
    // system counter restarted, matched through the slow clock
    acc(1, 5'h18, 64'h0, 1);
    acc(1, 5'h19, 64'h5, 1);
    wait_bit(16, 400);
    acc(0, 5'h18, 64'h0, 1);
    `CHK("system rate", 1'b1, rd >= 64'h5 && rd < 64'h7)
    finish_test;
  end
endmodule // tick_timers_soft_interrupts_tb
